// File: pdmc_defs.vh
`ifndef PDMC_DEFS_VH
`define PDMC_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PDMC_OFS_CTL1 4'h0
`define PDMC_OFS_CTL2 4'h1
`define PDMC_OFS_IEN 4'h2
`define PDMC_OFS_WKEN 4'h3
`define PDMC_OFS_STAT 4'h4

// ----------------------------------------------------------------
// Field positions, control register one
// ----------------------------------------------------------------
`define PDMC_C1_DEEP_STOP 7
`define PDMC_C1_SETTLE_HI 6
`define PDMC_C1_SETTLE_LO 4
`define PDMC_C1_LOW_SPEED 3
`define PDMC_C1_RSVD 2
`define PDMC_C1_MED_HI 1
`define PDMC_C1_MED_LO 0

// ----------------------------------------------------------------
// Field positions, control register two
// ----------------------------------------------------------------
`define PDMC_C2_NOISE_SEL 4
`define PDMC_C2_DIRECT 3
`define PDMC_C2_MED_SPEED 2
`define PDMC_C2_SUB_HI 1
`define PDMC_C2_SUB_LO 0

// ----------------------------------------------------------------
// Interrupt enable bits (peripheral and external sources)
// ----------------------------------------------------------------
`define PDMC_IEN_TIMER_A 0
`define PDMC_IEN_TIMER_F 1
`define PDMC_IEN_COUNTER 2
`define PDMC_IEN_SERIAL 3
`define PDMC_IEN_CONV 4
`define PDMC_IEN_EVENT 5
`define PDMC_IEN_EXT0 6
`define PDMC_IEN_EXT1 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PDMC_RST_SETTLE 3'h0
`define PDMC_RST_MED_DIV 2'h3
`define PDMC_RST_SUB_DIV 2'h0
`define PDMC_RST_IEN 8'h00
`define PDMC_RST_WKEN 8'h00

// ----------------------------------------------------------------
// Settling counts in states (one state is one clock)
// ----------------------------------------------------------------
`define PDMC_SETTLE_1K 15'd1024
`define PDMC_SETTLE_2K 15'd2048
`define PDMC_SETTLE_4K 15'd4096
`define PDMC_SETTLE_2 15'd2
`define PDMC_SETTLE_8 15'd8
`define PDMC_SETTLE_16 15'd16

// ----------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------
`define PDMC_M_ACT_HI 3'h0
`define PDMC_M_ACT_MED 3'h1
`define PDMC_M_SUB 3'h2
`define PDMC_M_SLP_HI 3'h3
`define PDMC_M_SLP_MED 3'h4
`define PDMC_M_STANDBY 3'h5
`define PDMC_M_WATCH 3'h6
`define PDMC_M_SETTLE 3'h7

`endif

// File: pdmc_top.v
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "pdmc_defs.vh"

module pdmc_top #(
   parameter [14:0] SETTLE_8K = 15'd8192,   // Settle code 000
   parameter [14:0] SETTLE_16K = 15'd16384  // Settle code 001
) (
   input wire I_CLK,                 // System clock, 10 MHz
   input wire I_ARST_N,              // Reset pin, active low
   input wire [3:0] I_ADDR,          // Register address
   input wire [7:0] I_WDATA,         // Register write data
   input wire I_WR,                  // Write strobe
   input wire I_RD,                  // Read strobe
   input wire I_HALT,                // Halt instruction pulse
   input wire I_IRQ_MASK,            // CPU interrupt mask bit
   input wire I_WATCH_TIMER_BIT,     // Watch timer bit of timer A
   input wire I_WATCH_TICK,          // Watch clock tick pulse
   input wire [4:0] I_PERIPH_IRQ,    // Timer A, F, counter, serial, converter
   input wire I_EVENT_IRQ,           // Event-count pin, async
   input wire [1:0] I_EXT_IRQ,       // External lines 1..0, async
   input wire [7:0] I_WAKE_PIN,      // Wake-up pins, async
   output reg [7:0] O_RDATA,         // Register read data
   output reg O_CPU_HALT,            // CPU stopped
   output reg O_PERIPH_RUN,          // Peripherals clocked
   output reg O_WATCH_RUN,           // Timer A/F, counter, display run
   output reg O_OSC_RUN,             // Oscillator enabled
   output reg O_CLK_SUPPLY,          // Clock supplied chip-wide
   output reg O_PIN_HIZ,             // Unpulled pins to high impedance
   output reg O_PORT_HOLD,           // Ports hold state
   output reg O_MED_SPEED,           // CPU on medium divider
   output reg [1:0] O_MED_DIV,       // Medium divider select
   output reg O_SUB_ACTIVE,          // CPU on subclock
   output reg O_CPU_TICK,            // Subactive CPU clock enable
   output reg O_IRQ_START,           // Start interrupt handling pulse
   output reg [2:0] O_MODE           // Present power mode
);

   // ----------------------------------------------------------------
   // Settle count decode
   // ----------------------------------------------------------------
   function [14:0] settle_len;
      input [2:0] code;
      begin
         case (code)
            3'h0: settle_len = SETTLE_8K;
            3'h1: settle_len = SETTLE_16K;
            3'h2: settle_len = `PDMC_SETTLE_1K;
            3'h3: settle_len = `PDMC_SETTLE_2K;
            3'h4: settle_len = `PDMC_SETTLE_4K;
            3'h5: settle_len = `PDMC_SETTLE_2;
            3'h6: settle_len = `PDMC_SETTLE_8;
            default: settle_len = `PDMC_SETTLE_16;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // Subclock divide decode, returns last count value
   // ----------------------------------------------------------------
   function [2:0] sub_last;
      input [1:0] code;
      begin
         if (code[1]) begin
            sub_last = 3'h1;
         end else if (code[0]) begin
            sub_last = 3'h3;
         end else begin
            sub_last = 3'h7;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   reg deep_stop_select_r;
   reg [2:0] settle_sel_r;
   reg low_speed_select_r;
   reg [1:0] medium_div_r;
   reg noise_sel_r;
   reg direct_switch_select_r;
   reg medium_speed_select_r;
   reg [1:0] sub_div_r;
   reg [7:0] irq_en_r;
   reg [7:0] wake_en_r;
   reg [10:0] sync1_r;
   reg [10:0] sync2_r;
   reg [2:0] mode_r;
   reg [2:0] mode_nxt;
   reg [14:0] settle_cnt_r;
   reg [14:0] settle_cnt_nxt;
   reg [2:0] sub_cnt_r;
   reg irq_pulse_nxt;
   wire [1:0] ext_s;
   wire [7:0] pin_s;
   wire event_s;
   wire wake_pins;
   wire any_wake;
   wire standby_wake;
   wire watch_wake;
   wire [7:0] ctl1_rd;
   wire [7:0] ctl2_rd;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Two stages for the event-count, external line and wake-up pin inputs
   always @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         sync1_r <= 11'h000;
         sync2_r <= 11'h000;
      end else begin
         sync1_r <= {I_EVENT_IRQ, I_EXT_IRQ, I_WAKE_PIN};
         sync2_r <= sync1_r;
      end
   end

   assign pin_s = sync2_r[7:0];
   assign ext_s = sync2_r[9:8];
   assign event_s = sync2_r[10];

   // ----------------------------------------------------------------
   // Wake request qualification
   // ----------------------------------------------------------------
   // Every source gated by its enable and the CPU mask
   assign wake_pins = |(pin_s & wake_en_r);
   assign any_wake = !I_IRQ_MASK &&
      (|(I_PERIPH_IRQ & irq_en_r[4:0]) || (event_s && irq_en_r[`PDMC_IEN_EVENT]) ||
       (ext_s[0] && irq_en_r[`PDMC_IEN_EXT0]) || (ext_s[1] && irq_en_r[`PDMC_IEN_EXT1]) ||
       wake_pins);
   assign standby_wake = !I_IRQ_MASK &&
      ((ext_s[0] && irq_en_r[`PDMC_IEN_EXT0]) || (ext_s[1] && irq_en_r[`PDMC_IEN_EXT1]) ||
       wake_pins);
   assign watch_wake = !I_IRQ_MASK &&
      ((I_PERIPH_IRQ[0] && irq_en_r[`PDMC_IEN_TIMER_A]) ||
       (I_PERIPH_IRQ[1] && irq_en_r[`PDMC_IEN_TIMER_F]) ||
       (ext_s[0] && irq_en_r[`PDMC_IEN_EXT0]) || wake_pins);

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // Control registers, enables
   always @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         deep_stop_select_r <= 1'b0;
         settle_sel_r <= `PDMC_RST_SETTLE;
         low_speed_select_r <= 1'b0;
         medium_div_r <= `PDMC_RST_MED_DIV;
         noise_sel_r <= 1'b1;
         direct_switch_select_r <= 1'b0;
         medium_speed_select_r <= 1'b0;
         sub_div_r <= `PDMC_RST_SUB_DIV;
         irq_en_r <= `PDMC_RST_IEN;
         wake_en_r <= `PDMC_RST_WKEN;
      end else if (I_WR) begin
         if (I_ADDR == `PDMC_OFS_CTL1) begin
            deep_stop_select_r <= I_WDATA[`PDMC_C1_DEEP_STOP];
            settle_sel_r <= I_WDATA[`PDMC_C1_SETTLE_HI:`PDMC_C1_SETTLE_LO];
            low_speed_select_r <= I_WDATA[`PDMC_C1_LOW_SPEED];
            medium_div_r <= I_WDATA[`PDMC_C1_MED_HI:`PDMC_C1_MED_LO];
         end else if (I_ADDR == `PDMC_OFS_CTL2) begin
            noise_sel_r <= I_WDATA[`PDMC_C2_NOISE_SEL];
            direct_switch_select_r <= I_WDATA[`PDMC_C2_DIRECT];
            medium_speed_select_r <= I_WDATA[`PDMC_C2_MED_SPEED];
            if (mode_r != `PDMC_M_SUB) begin
               sub_div_r <= I_WDATA[`PDMC_C2_SUB_HI:`PDMC_C2_SUB_LO];
            end
         end else if (I_ADDR == `PDMC_OFS_IEN) begin
            irq_en_r <= I_WDATA;
         end else if (I_ADDR == `PDMC_OFS_WKEN) begin
            wake_en_r <= I_WDATA;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   // Reserved bits read as one
   assign ctl1_rd = {deep_stop_select_r, settle_sel_r, low_speed_select_r, 1'b1, medium_div_r};
   assign ctl2_rd = {3'h7, noise_sel_r, direct_switch_select_r, medium_speed_select_r, sub_div_r};

   // Read data one cycle after the strobe, zero otherwise
   always @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_RDATA <= 8'h00;
      end else if (I_RD) begin
         if (I_ADDR == `PDMC_OFS_CTL1) begin
            O_RDATA <= ctl1_rd;
         end else if (I_ADDR == `PDMC_OFS_CTL2) begin
            O_RDATA <= ctl2_rd;
         end else if (I_ADDR == `PDMC_OFS_IEN) begin
            O_RDATA <= irq_en_r;
         end else if (I_ADDR == `PDMC_OFS_WKEN) begin
            O_RDATA <= wake_en_r;
         end else if (I_ADDR == `PDMC_OFS_STAT) begin
            O_RDATA <= {5'h00, mode_r};
         end else begin
            O_RDATA <= 8'h00;
         end
      end else begin
         O_RDATA <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Mode sequencer
   // ----------------------------------------------------------------
   // Next mode, settle count and handling pulse
   always @* begin
      mode_nxt = mode_r;
      settle_cnt_nxt = settle_cnt_r;
      irq_pulse_nxt = 1'b0;
      case (mode_r)
         `PDMC_M_ACT_HI, `PDMC_M_ACT_MED: begin
            if (I_HALT) begin
               if (deep_stop_select_r && I_WATCH_TIMER_BIT) begin
                  mode_nxt = `PDMC_M_WATCH;
               end else if (deep_stop_select_r && !low_speed_select_r) begin
                  mode_nxt = `PDMC_M_STANDBY;
               end else if (!deep_stop_select_r && !low_speed_select_r &&
                            !direct_switch_select_r) begin
                  if (medium_speed_select_r) begin
                     mode_nxt = `PDMC_M_SLP_MED;
                  end else begin
                     mode_nxt = `PDMC_M_SLP_HI;
                  end
               end
            end
         end
         `PDMC_M_SUB: begin
            if (I_HALT && deep_stop_select_r && I_WATCH_TIMER_BIT) begin
               mode_nxt = `PDMC_M_WATCH;
            end
         end
         `PDMC_M_SLP_HI, `PDMC_M_SLP_MED: begin
            if (any_wake) begin
               irq_pulse_nxt = 1'b1;
               if (mode_r == `PDMC_M_SLP_MED) begin
                  mode_nxt = `PDMC_M_ACT_MED;
               end else begin
                  mode_nxt = `PDMC_M_ACT_HI;
               end
            end
         end
         `PDMC_M_STANDBY: begin
            if (standby_wake) begin
               mode_nxt = `PDMC_M_SETTLE;
               settle_cnt_nxt = settle_len(settle_sel_r) - 15'd1;
            end
         end
         `PDMC_M_WATCH: begin
            if (watch_wake) begin
               if (low_speed_select_r) begin
                  mode_nxt = `PDMC_M_SUB;
                  irq_pulse_nxt = 1'b1;
               end else begin
                  mode_nxt = `PDMC_M_SETTLE;
                  settle_cnt_nxt = settle_len(settle_sel_r) - 15'd1;
               end
            end
         end
         default: begin
            if (settle_cnt_r == 15'd0) begin
               irq_pulse_nxt = 1'b1;
               if (medium_speed_select_r) begin
                  mode_nxt = `PDMC_M_ACT_MED;
               end else begin
                  mode_nxt = `PDMC_M_ACT_HI;
               end
            end else begin
               settle_cnt_nxt = settle_cnt_r - 15'd1;
            end
         end
      endcase
   end

   // Mode state, reset lands in medium-speed active
   always @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         mode_r <= `PDMC_M_ACT_MED;
         settle_cnt_r <= 15'd0;
         O_IRQ_START <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         settle_cnt_r <= settle_cnt_nxt;
         O_IRQ_START <= irq_pulse_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Subactive CPU clock divider
   // ----------------------------------------------------------------
   // Counts watch ticks, pulses every 8, 4 or 2
   always @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         sub_cnt_r <= 3'h0;
         O_CPU_TICK <= 1'b0;
      end else if (mode_r != `PDMC_M_SUB) begin
         sub_cnt_r <= 3'h0;
         O_CPU_TICK <= 1'b0;
      end else if (I_WATCH_TICK) begin
         if (sub_cnt_r >= sub_last(sub_div_r)) begin
            sub_cnt_r <= 3'h0;
            O_CPU_TICK <= 1'b1;
         end else begin
            sub_cnt_r <= sub_cnt_r + 3'h1;
            O_CPU_TICK <= 1'b0;
         end
      end else begin
         O_CPU_TICK <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Power control outputs
   // ----------------------------------------------------------------
   // Registered decode of the next mode; oscillator runs during reset
   always @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_CPU_HALT <= 1'b0;
         O_PERIPH_RUN <= 1'b1;
         O_WATCH_RUN <= 1'b1;
         O_OSC_RUN <= 1'b1;
         O_CLK_SUPPLY <= 1'b1;
         O_PIN_HIZ <= 1'b0;
         O_PORT_HOLD <= 1'b0;
         O_MED_SPEED <= 1'b1;
         O_MED_DIV <= `PDMC_RST_MED_DIV;
         O_SUB_ACTIVE <= 1'b0;
         O_MODE <= `PDMC_M_ACT_MED;
      end else begin
         O_CPU_HALT <= (mode_nxt != `PDMC_M_ACT_HI) && (mode_nxt != `PDMC_M_ACT_MED) &&
            (mode_nxt != `PDMC_M_SUB);
         O_PERIPH_RUN <= (mode_nxt == `PDMC_M_ACT_HI) || (mode_nxt == `PDMC_M_ACT_MED) ||
            (mode_nxt == `PDMC_M_SLP_HI) || (mode_nxt == `PDMC_M_SLP_MED);
         O_WATCH_RUN <= (mode_nxt != `PDMC_M_STANDBY) && (mode_nxt != `PDMC_M_SETTLE);
         O_OSC_RUN <= (mode_nxt != `PDMC_M_STANDBY) && (mode_nxt != `PDMC_M_WATCH) &&
            (mode_nxt != `PDMC_M_SUB);
         O_CLK_SUPPLY <= (mode_nxt != `PDMC_M_STANDBY) && (mode_nxt != `PDMC_M_WATCH) &&
            (mode_nxt != `PDMC_M_SETTLE) && (mode_nxt != `PDMC_M_SUB);
         O_PIN_HIZ <= (mode_nxt == `PDMC_M_STANDBY);
         O_PORT_HOLD <= (mode_nxt == `PDMC_M_WATCH);
         O_MED_SPEED <= (mode_nxt == `PDMC_M_ACT_MED) || (mode_nxt == `PDMC_M_SLP_MED);
         O_MED_DIV <= medium_div_r;
         O_SUB_ACTIVE <= (mode_nxt == `PDMC_M_SUB);
         O_MODE <= mode_nxt;
      end
   end

endmodule

// File: pdmc_top_properties.sv
`timescale 1ns/1ps
module pdmc_props #(
   parameter [14:0] SETTLE_8K = 15'd8192,  // Settle code 000
   parameter [14:0] SETTLE_16K = 15'd16384 // Settle code 001
) (
   input wire I_CLK,        // System clock
   input wire I_ARST_N,     // Reset pin
   input wire I_HALT,       // Halt pulse
   input wire I_IRQ_MASK,   // Interrupt mask
   input wire I_WATCH_TICK, // Watch tick
   input wire [2:0] O_MODE, // Power mode
   input wire O_CPU_HALT,   // CPU stopped
   input wire O_PERIPH_RUN, // Peripherals run
   input wire O_WATCH_RUN,  // Watch blocks run
   input wire O_OSC_RUN,    // Oscillator on
   input wire O_CLK_SUPPLY, // Clock supplied
   input wire O_PIN_HIZ,    // Pins floated
   input wire O_PORT_HOLD,  // Ports held
   input wire O_MED_SPEED,  // Medium speed
   input wire O_SUB_ACTIVE, // CPU on subclock
   input wire O_CPU_TICK,   // Subactive tick
   input wire O_IRQ_START   // Handling start
);
   // ----------------------------------------
   // Mode relations
   // ----------------------------------------
   default clocking @(posedge I_CLK);
   endclocking
   default disable iff (!I_ARST_N);

   resume_speed_a: assert property (O_MODE <= 3'h1 |-> O_MED_SPEED == O_MODE[0])
      else $error("active speed does not match mode");
   sub_tick_a: assert property (O_CPU_TICK |-> $past(O_MODE) == 3'h2 && $past(I_WATCH_TICK))
      else $error("subactive tick without watch tick");
   sleep_hi_a: assert property (O_MODE == 3'h3 |-> O_CPU_HALT && O_PERIPH_RUN && !O_MED_SPEED)
      else $error("high sleep outputs wrong");
   sleep_wake_a: assert property (O_MODE == 3'h3 |=> O_MODE == 3'h3 || (O_MODE == 3'h0 && O_IRQ_START))
      else $error("high sleep left wrongly");
   med_wake_a: assert property (O_MODE == 3'h4 |=> O_MODE == 3'h4 || (O_MODE == 3'h1 && O_IRQ_START))
      else $error("medium sleep left wrongly");
   mask_hold_a: assert property ((O_MODE >= 3'h3 && O_MODE <= 3'h6 && I_IRQ_MASK) |=> $stable(O_MODE))
      else $error("masked wake left low power");
   standby_pins_a: assert property (O_MODE == 3'h5 |-> !O_OSC_RUN && O_PIN_HIZ && !O_PERIPH_RUN)
      else $error("standby outputs wrong");
   standby_exit_a: assert property (O_MODE == 3'h5 |=> O_MODE == 3'h5 || O_MODE == 3'h7)
      else $error("standby left without settling");
   settle_clock_a: assert property (O_MODE == 3'h7 |-> O_OSC_RUN && !O_CLK_SUPPLY && !O_IRQ_START)
      else $error("clock supplied during settling");
   watch_run_a: assert property (O_MODE == 3'h6 |-> O_WATCH_RUN && O_PORT_HOLD && !O_PERIPH_RUN)
      else $error("watch outputs wrong");
   start_cause_a: assert property (O_IRQ_START |-> O_MODE <= 3'h2 && $past(O_MODE) >= 3'h3)
      else $error("handling start without wake");
   halt_only_a: assert property ((O_MODE <= 3'h2 && !I_HALT) |=> O_MODE <= 3'h2)
      else $error("low power entered without halt");
   reset_med_a: assert property ($rose(I_ARST_N) |-> O_MODE == 3'h1 && O_MED_SPEED)
      else $error("reset did not give medium active");
   sub_flag_a: assert property (O_SUB_ACTIVE == (O_MODE == 3'h2))
      else $error("subclock flag does not match mode");
endmodule

bind pdmc_top pdmc_props #(.SETTLE_8K(SETTLE_8K), .SETTLE_16K(SETTLE_16K)) u_props (
   .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_HALT(I_HALT), .I_IRQ_MASK(I_IRQ_MASK),
   .I_WATCH_TICK(I_WATCH_TICK), .O_MODE(O_MODE), .O_CPU_HALT(O_CPU_HALT), .O_PERIPH_RUN(O_PERIPH_RUN),
   .O_WATCH_RUN(O_WATCH_RUN), .O_OSC_RUN(O_OSC_RUN), .O_CLK_SUPPLY(O_CLK_SUPPLY), .O_PIN_HIZ(O_PIN_HIZ),
   .O_PORT_HOLD(O_PORT_HOLD), .O_MED_SPEED(O_MED_SPEED), .O_CPU_TICK(O_CPU_TICK), .O_IRQ_START(O_IRQ_START),
   .O_SUB_ACTIVE(O_SUB_ACTIVE));

// File: pdmc_partner.sv
`timescale 1ns/1ps
module pdmc_partner (
   input wire i_clk,             // System clock
   input wire i_fire,            // Raise one line
   input wire [3:0] i_sel,       // 0-7 pins, 8-9 lines, 10 event
   output logic [7:0] o_wake_pin, // Wake pins
   output logic [1:0] o_ext_irq,  // External lines
   output logic o_event_irq       // Event-count pin
);
   logic [10:0] lines = 11'h000;

   // ----------------------------------------
   // Asynchronous pulse, four clocks high
   // ----------------------------------------
   assign {o_event_irq, o_ext_irq, o_wake_pin} = lines;

   // Edges land between clocks; the high level holds over four clocks
   always @(posedge i_clk) begin
      if (i_fire) begin
         #37 lines[i_sel] = 1'b1;
         repeat (4) @(posedge i_clk);
         #23 lines[i_sel] = 1'b0;
      end
   end
endmodule

// File: power_down_mode_controller_tb.sv
`timescale 1ns/1ps
module power_down_mode_controller_tb;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic halt = 1'b0;
   logic mask = 1'b0;
   logic wbit = 1'b0;
   logic wtick = 1'b0;
   logic [4:0] pirq = 5'h00;
   logic fire_s = 1'b0;
   logic [3:0] sel = 4'h0;
   logic ev;
   logic [1:0] ext;
   logic [7:0] pin;
   logic [7:0] rdata;
   logic [2:0] mode;
   logic [1:0] mdiv;
   logic pinhiz, porthold, irq_start, cpu_tick;
   logic [15:0] ticks = 16'h0;
   logic [16:0] seed;
   int bad_count = 0;
   int checks_done = 0;

   // ----------------------------------------
   // Design, far side and clock
   // ----------------------------------------
   pdmc_top #(.SETTLE_8K(15'd16), .SETTLE_16K(15'd32)) uut (
      .I_CLK(clk), .I_ARST_N(arst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s),
      .I_HALT(halt), .I_IRQ_MASK(mask), .I_WATCH_TIMER_BIT(wbit), .I_WATCH_TICK(wtick),
      .I_PERIPH_IRQ(pirq), .I_EVENT_IRQ(ev), .I_EXT_IRQ(ext), .I_WAKE_PIN(pin), .O_RDATA(rdata),
      .O_CPU_HALT(), .O_PERIPH_RUN(), .O_WATCH_RUN(), .O_OSC_RUN(), .O_CLK_SUPPLY(),
      .O_PIN_HIZ(pinhiz), .O_PORT_HOLD(porthold), .O_MED_SPEED(), .O_MED_DIV(mdiv),
      .O_SUB_ACTIVE(), .O_CPU_TICK(cpu_tick), .O_IRQ_START(irq_start), .O_MODE(mode));
   pdmc_partner far_side (.i_clk(clk), .i_fire(fire_s), .i_sel(sel), .o_wake_pin(pin),
      .o_ext_irq(ext), .o_event_irq(ev));

   always #50 clk = ~clk;

   // Counts subactive CPU ticks
   always @(posedge clk) begin
      if (cpu_tick === 1'b1) ticks <= ticks + 16'h1;
   end

   // ----------------------------------------
   // Expectation functions and tasks
   // ----------------------------------------
   function automatic logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction

   // Settling states, first two codes scaled down
   function automatic logic [15:0] settle_n(input logic [2:0] c);
      case (c)
         3'h0: return 16'd16;
         3'h1: return 16'd32;
         3'h2: return 16'd1024;
         3'h3: return 16'd2048;
         3'h4: return 16'd4096;
         3'h5: return 16'd2;
         3'h6: return 16'd8;
         default: return 16'd16;
      endcase
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chm(input logic [2:0] e);
      chk({13'h0, mode}, {13'h0, e});
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk({8'h00, rdata}, {8'h00, e});
   endtask

   task automatic do_halt();
      @(posedge clk);
      halt <= 1'b1;
      @(posedge clk);
      halt <= 1'b0;
      #1;
   endtask

   task automatic fire(input logic [3:0] s);
      @(posedge clk);
      sel <= s;
      fire_s <= 1'b1;
      @(posedge clk);
      fire_s <= 1'b0;
   endtask

   task automatic wait_mode(input logic [2:0] m, input int lim);
      int n;
      n = 0;
      while (mode !== m && n < lim) begin
         @(posedge clk);
         #1 n++;
      end
      chm(m);
   endtask

   // Counts cycles spent settling, then checks the resumed mode
   task automatic settle_chk(input logic [15:0] en, input logic [2:0] em);
      logic [15:0] n;
      n = 16'h0;
      wait_mode(3'h7, 8);
      while (mode === 3'h7 && n < 16'd20000) begin
         @(posedge clk);
         #1 n++;
      end
      chk(n, en);
      chm(em);
      chk({15'h0, irq_start}, 16'h1);
   endtask

   task automatic complete_run();
      if (bad_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 17'd72564;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      rd(4'h0, 8'h07);
      rd(4'h1, 8'hf0);
      rd(4'h4, 8'h01);
      wr(4'h9, 8'h5a);
      rd(4'h9, 8'h00);
      seed = lfsr(seed);
      wr(4'h3, seed[7:0]);
      rd(4'h3, seed[7:0]);
      wr(4'h2, 8'hff);
      wr(4'h3, 8'hff);
      wr(4'h0, {6'h00, seed[9:8]});
      rd(4'h0, {6'h01, seed[9:8]});
      chk({14'h0, mdiv}, {14'h0, seed[9:8]});
      // High sleep, masked then released
      wr(4'h1, 8'h10);
      do_halt();
      chm(3'h3);
      @(posedge clk);
      mask <= 1'b1;
      pirq <= 5'h01;
      repeat (6) @(posedge clk);
      #1 chm(3'h3);
      @(posedge clk);
      mask <= 1'b0;
      wait_mode(3'h0, 4);
      chk({15'h0, irq_start}, 16'h1);
      @(posedge clk);
      pirq <= 5'h00;
      // Medium sleep, woken by a random pin
      wr(4'h1, 8'h14);
      do_halt();
      chm(3'h4);
      seed = lfsr(seed);
      fire({1'b0, seed[2:0]});
      wait_mode(3'h1, 6);
      repeat (6) @(posedge clk);
      // Standby over every settle code
      for (int c = 0; c < 8; c++) begin
         wr(4'h0, {1'b1, c[2:0], 4'h7});
         wr(4'h1, {4'h1, 1'b0, c[0], 2'h0});
         do_halt();
         chm(3'h5);
         chk({15'h0, pinhiz}, 16'h1);
         @(posedge clk);
         pirq <= 5'h01;
         repeat (4) @(posedge clk);
         #1 chm(3'h5);
         @(posedge clk);
         pirq <= 5'h00;
         fire({3'h4, c[0]});
         settle_chk(settle_n(c[2:0]), {2'h0, c[0]});
         repeat (6) @(posedge clk);
      end
      // Watch, each wake target
      wbit <= 1'b1;
      for (int t = 0; t < 3; t++) begin
         wr(4'h0, {4'he, t[1], 3'h7});
         wr(4'h1, {4'h1, 1'b0, t[0], 2'h0});
         do_halt();
         chm(3'h6);
         chk({15'h0, porthold}, 16'h1);
         @(posedge clk);
         pirq <= 5'h08;
         repeat (4) @(posedge clk);
         #1 chm(3'h6);
         @(posedge clk);
         pirq <= 5'h00;
         fire(4'h8);
         if (t == 2) begin
            wait_mode(3'h2, 6);
         end else begin
            settle_chk(16'd8, t[2:0]);
         end
         repeat (6) @(posedge clk);
      end
      // Subactive divider locked at divide by eight
      wr(4'h1, 8'h13);
      rd(4'h1, 8'hf0);
      repeat (16) begin
         @(posedge clk);
         wtick <= 1'b1;
         @(posedge clk);
         wtick <= 1'b0;
      end
      repeat (2) @(posedge clk);
      #1 chk(ticks, 16'd2);
      do_halt();
      chm(3'h6);
      // Reset pin while in watch
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chm(3'h1);
      @(posedge clk);
      arst_n <= 1'b1;
      rd(4'h1, 8'hf0);
      complete_run();
   end

   // Watchdog against a hang
   initial begin
      #3000000;
      bad_count++;
      complete_run();
   end
endmodule
